// ---- design/dvp_pkg.sv ----
// constants, register map and state type for the dv transmit pacer
// assumes a 50 MHz system clock and a 9-bit configuration address
package dvp_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_NS = 20;
	localparam int CYCLE_US = 125;
	localparam int CYCLE_CLKS = CYCLE_US * 1000 / CLK_NS;
	localparam int NTSC_GAP = 3280;
	localparam int NTSC_LAST_GAP = 3300;
	localparam int NTSC_EVENTS = 250;
	localparam int PAL_GAP = 3277;
	localparam int PAL_LAST_GAP = 3217;
	localparam int PAL_EVENTS = 300;
	// ----------------------------------------
	// packet shape
	// ----------------------------------------
	localparam int WORD_W = 32;
	localparam int FIFO_DEPTH = 8;
	localparam int SRC_QUADS = 120;
	localparam int HDIF_PERIOD = 25;
	localparam int HDIF_QUADS = 20;
	localparam logic [15:0] SRC_LEN = 16'h01e8;
	localparam logic [15:0] NIL_LEN = 16'h0008;
	localparam logic [7:0] DBLK_PER_SRC = 8'h01;
	localparam logic [15:0] SYT_NONE = 16'hffff;
	localparam logic [31:0] HDIF_FILL = 32'hffffffff;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [8:0] OFF_TS_CTRL = 9'h0f0;
	localparam logic [8:0] OFF_HDIF0 = 9'h1a4;
	localparam logic [8:0] OFF_HDIF1 = 9'h1a8;
	localparam logic [8:0] OFF_CIP0 = 9'h1cc;
	localparam logic [8:0] OFF_CIP1 = 9'h1d0;
	localparam logic [8:0] OFF_MODE = 9'h1e0;
	localparam logic [8:0] OFF_STATUS = 9'h1e4;
	localparam logic [8:0] OFF_ISOHDR = 9'h1e8;
	localparam logic [8:0] OFF_BULK_PART = 9'h1ec;
	localparam logic [8:0] OFF_CTRL_PART = 9'h1f0;
	localparam logic [31:0] MODE_RESET = 32'h00000001;
	localparam logic [31:0] ZERO_RESET = 32'h00000000;
	localparam int MB_EMPTY_INS = 0;
	localparam int MB_TX_EN = 1;
	localparam int MB_HDIF_INS = 2;
	localparam int MB_HDIF_APP = 3;
	localparam int MB_CIP_INS = 4;
	localparam int TS_EN_BIT = 0;
	localparam int TS_FRAME_BIT = 11;
	localparam int FLAG5060_BIT = 23;
	localparam int SIGTYPE_LSB = 18;
	localparam logic [4:0] SIGTYPE_SD = 5'h00;
	localparam logic [4:0] SIGTYPE_HD = 5'h02;
	typedef enum {DVP_IDLE, DVP_ISO, DVP_CIP0, DVP_CIP1, DVP_DATA} dvp_state_t;
endpackage

// ---- design/dvp_stream_if.sv ----
// valid/ready word stream between the pacer and its fifo
// assumes both ends share one clock
`timescale 1ns/1ps
interface dvp_stream_if #(parameter int W = 32);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ---- design/dvp_fifo.sv ----
// small synchronous fifo, width and depth as parameters
// assumes depth is a power of two
`timescale 1ns/1ps
module dvp_fifo #(
	parameter int W = 32,
	parameter int D = 8
) (
	input wire logic clk_in,
	input wire logic reset_in,
	dvp_stream_if.snk push,
	dvp_stream_if.src pop
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL = (AW+1)'(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [AW:0] count;
	wire do_push = push.valid && push.ready;
	wire do_pop = pop.valid && pop.ready;

	// honest full and empty from the fill count
	assign push.ready = (count != FULL);
	assign pop.valid = (count != '0);
	assign pop.data = mem[rptr];

	// storage has no reset, only the pointers and count do
	always_ff @(posedge clk_in)
	begin
		if (do_push)
			mem[wptr] <= push.data;
	end

	// pointers wrap naturally at the power-of-two depth
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end
		else
		begin
			if (do_push)
				wptr <= wptr + 1'b1;
			if (do_pop)
				rptr <= rptr + 1'b1;
			if (do_push && !do_pop)
				count <= count + 1'b1;
			else if (do_pop && !do_push)
				count <= count - 1'b1;
		end
	end
endmodule

// ---- design/dvp_pacer.sv ----
// dv transmit pacer: paces source packets, builds iso/cip headers, inserts dif block
// assumes synchronous inputs, 50 MHz clock, link sink honouring valid/ready
`timescale 1ns/1ps
// How it works
// - 250 source-packet events per NTSC frame, 300 per PAL frame.
// - pacing counter advances on a half-rate enable of the system clock.
// - first application frame pulse starts the source-packet counter.
// - empty-packet insertion on after reset; mode bit clear turns it off.
// - NTSC: 249 gaps of 3280 pacing clocks, then one of 3300.
// - PAL: 299 gaps of 3277 pacing clocks, then one of 3217.
// - cycle-sync event every 125 microseconds.
// - one packet per iso cycle, source or empty.
// - no source event since last cycle sync gives an empty packet.
// - source event but no complete packet buffered gives an empty packet.
// - header dif block fills first 80 bytes of every 25th source packet.
// - dif block words 0-1 come from two programmable words, the rest is all-ones fill.
// - dif bytes 0-7 inserted here or passed from the application.
// - cip quadlets built from two programmable words.
// - timestamp goes in next cycle's first packet, or next frame's first.
// - iso length 488 for source packet, 8 for empty packet.
// - only length, syt and dbc are computed; rest from configuration.
// - signal type plus 50/60 flag picks system; other codes reserved.
// - bulky fifo partition sizes held in steps of four quadlets.
// - control fifo partition sizes held in quadlet steps.
module dvp_pacer #(
	parameter int CYCLE_CLKS = dvp_pkg::CYCLE_CLKS
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic [8:0] cfg_addr_in,
	input wire logic cfg_wr_in,
	input wire logic cfg_rd_in,
	input wire logic [dvp_pkg::WORD_W-1:0] cfg_wdata_in,
	output logic [dvp_pkg::WORD_W-1:0] cfg_rdata_out,
	input wire logic frame_sync_pulse_in,
	input wire logic src_packet_ready_in,
	input wire logic bdp_valid_in,
	input wire logic [dvp_pkg::WORD_W-1:0] bdp_data_in,
	output logic bdp_ready_out,
	output logic tx_valid_out,
	output logic [dvp_pkg::WORD_W-1:0] tx_data_out,
	output logic tx_last_out,
	input wire logic tx_ready_in,
	output logic cycle_sync_out,
	output logic src_event_out
);
	import dvp_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// gap length in pacing clocks for the coming event
	function automatic logic [11:0] gap_len(input logic pal, input logic last);
		if (pal)
			gap_len = last ? 12'(PAL_LAST_GAP) : 12'(PAL_GAP);
		else
			gap_len = last ? 12'(NTSC_LAST_GAP) : 12'(NTSC_GAP);
	endfunction

	function automatic logic [8:0] last_event(input logic pal);
		last_event = pal ? 9'(PAL_EVENTS - 1) : 9'(NTSC_EVENTS - 1);
	endfunction

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	logic [31:0] ts_ctrl;
	logic [31:0] hdif0;
	logic [31:0] hdif1;
	logic [31:0] cip0;
	logic [31:0] cip1;
	logic [31:0] mode;
	logic [31:0] iso_fields;
	logic [31:0] bulk_part;
	logic [31:0] ctrl_part;
	logic [31:0] status;
	logic [31:0] next_rdata;

	wire wr_ts = cfg_wr_in && cfg_addr_in == OFF_TS_CTRL;
	wire wr_h0 = cfg_wr_in && cfg_addr_in == OFF_HDIF0;
	wire wr_h1 = cfg_wr_in && cfg_addr_in == OFF_HDIF1;
	wire wr_c0 = cfg_wr_in && cfg_addr_in == OFF_CIP0;
	wire wr_c1 = cfg_wr_in && cfg_addr_in == OFF_CIP1;
	wire wr_md = cfg_wr_in && cfg_addr_in == OFF_MODE;
	wire wr_ih = cfg_wr_in && cfg_addr_in == OFF_ISOHDR;
	wire wr_bp = cfg_wr_in && cfg_addr_in == OFF_BULK_PART;
	wire wr_cp = cfg_wr_in && cfg_addr_in == OFF_CTRL_PART;

	// partition sizes: bulky sizes in hexlets, low two quadlet bits forced zero
	wire [31:0] bulk_wdata = {cfg_wdata_in[31:2], 2'b00};
	wire [31:0] ctrl_wdata = {8'h00, cfg_wdata_in[23:0]};

	// mode decode
	wire empty_ins = mode[MB_EMPTY_INS];
	wire tx_en = mode[MB_TX_EN];
	wire hdif_ins = mode[MB_HDIF_INS];
	wire hdif_app = mode[MB_HDIF_APP];
	wire cip_ins = mode[MB_CIP_INS];
	wire ts_en = ts_ctrl[TS_EN_BIT];
	wire ts_frame = ts_ctrl[TS_FRAME_BIT];

	// system decode from the signal type code and 50/60 flag
	wire [4:0] signal_type_code = cip1[SIGTYPE_LSB +: 5];
	wire pal = cip1[FLAG5060_BIT];
	wire sigtype_ok = signal_type_code == SIGTYPE_SD || signal_type_code == SIGTYPE_HD;
	wire sigtype_hd = signal_type_code == SIGTYPE_HD;

	// register writes; mode resets with empty insertion on
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			ts_ctrl <= ZERO_RESET;
			hdif0 <= ZERO_RESET;
			hdif1 <= ZERO_RESET;
			cip0 <= ZERO_RESET;
			cip1 <= ZERO_RESET;
			mode <= MODE_RESET;
			iso_fields <= ZERO_RESET;
			bulk_part <= ZERO_RESET;
			ctrl_part <= ZERO_RESET;
		end
		else
		begin
			if (wr_ts)
				ts_ctrl <= cfg_wdata_in;
			if (wr_h0)
				hdif0 <= cfg_wdata_in;
			if (wr_h1)
				hdif1 <= cfg_wdata_in;
			if (wr_c0)
				cip0 <= cfg_wdata_in;
			if (wr_c1)
				cip1 <= cfg_wdata_in;
			if (wr_md)
				mode <= cfg_wdata_in;
			if (wr_ih)
				iso_fields <= cfg_wdata_in;
			if (wr_bp)
				bulk_part <= bulk_wdata;
			if (wr_cp)
				ctrl_part <= ctrl_wdata;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb
	begin
		case (cfg_addr_in)
			OFF_TS_CTRL: next_rdata = ts_ctrl;
			OFF_HDIF0: next_rdata = hdif0;
			OFF_HDIF1: next_rdata = hdif1;
			OFF_CIP0: next_rdata = cip0;
			OFF_CIP1: next_rdata = cip1;
			OFF_MODE: next_rdata = mode;
			OFF_STATUS: next_rdata = status;
			OFF_ISOHDR: next_rdata = iso_fields;
			OFF_BULK_PART: next_rdata = bulk_part;
			OFF_CTRL_PART: next_rdata = ctrl_part;
			default: next_rdata = ZERO_RESET;
		endcase
	end

	// read data is registered, valid the cycle after the read strobe
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
			cfg_rdata_out <= ZERO_RESET;
		else if (cfg_rd_in)
			cfg_rdata_out <= next_rdata;
	end

	// ----------------------------------------
	// pacing
	// ----------------------------------------
	logic pace_en;
	logic frame_hold;
	logic started;
	logic [11:0] pace_cnt;
	logic [8:0] ev_idx;
	logic [15:0] pace_free;

	wire ev_last = ev_idx == last_event(pal);
	wire [11:0] gap_now = gap_len(pal, ev_last);
	wire gap_done = pace_cnt == gap_now - 12'd1;
	wire src_event = started && pace_en && gap_done;
	wire frame_edge = src_event && ev_last;

	// half-rate enable stands in for the divided pacing clock
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
			pace_en <= 1'b0;
		else
			pace_en <= ~pace_en;
	end

	// frame pulse held until the pacing edge, then starts counting once
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
			frame_hold <= 1'b0;
		else if (frame_sync_pulse_in && !started)
			frame_hold <= 1'b1;
		else if (pace_en)
			frame_hold <= 1'b0;
	end

	// event counter wraps after the last gap so each frame has a fixed count
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			started <= 1'b0;
			pace_cnt <= '0;
			ev_idx <= '0;
			pace_free <= '0;
		end
		else if (pace_en)
		begin
			pace_free <= pace_free + 16'd1;
			if (!started && frame_hold)
			begin
				started <= 1'b1;
				pace_cnt <= '0;
				ev_idx <= '0;
			end
			else if (started)
			begin
				if (gap_done)
				begin
					pace_cnt <= '0;
					ev_idx <= ev_last ? 9'd0 : ev_idx + 9'd1;
				end
				else
					pace_cnt <= pace_cnt + 12'd1;
			end
		end
	end

	// ----------------------------------------
	// cycle sync and packet decision
	// ----------------------------------------
	logic [12:0] cyc_cnt;
	logic src_seen;
	wire cs_event = cyc_cnt == 13'(CYCLE_CLKS - 1);

	// 125 us cycle timer from the system clock
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
			cyc_cnt <= '0;
		else if (cs_event)
			cyc_cnt <= '0;
		else
			cyc_cnt <= cyc_cnt + 13'd1;
	end

	// an event coinciding with cycle sync counts for the next cycle
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
			src_seen <= 1'b0;
		else
			src_seen <= src_event || (src_seen && !cs_event);
	end

	// without insertion a buffered packet goes whenever it is ready
	wire send_src = empty_ins ? (src_seen && src_packet_ready_in) : src_packet_ready_in;

	// ----------------------------------------
	// packet builder
	// ----------------------------------------
	dvp_state_t state;
	dvp_state_t next_state;
	logic is_src;
	logic [6:0] q_idx;
	logic [4:0] hdif_cnt;
	logic [7:0] dbc;
	logic [15:0] syt;
	logic ts_pending;
	logic ts_armed;

	dvp_stream_if #(.W(WORD_W)) in_s ();
	dvp_stream_if #(.W(WORD_W)) out_s ();

	// back-pressure of the link reaches the application through the fifo
	dvp_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) dvp_fifo_inst (
		.clk_in(ref_clk_in),
		.reset_in(reset_in),
		.push(in_s.snk),
		.pop(out_s.src)
	);
	assign in_s.valid = bdp_valid_in;
	assign in_s.data = bdp_data_in;
	assign bdp_ready_out = in_s.ready;

	wire adv = !tx_valid_out || tx_ready_in;
	wire start_pkt = state == DVP_IDLE && cs_event && tx_en;
	wire pop_now = state == DVP_DATA && adv && out_s.valid;
	assign out_s.ready = pop_now;
	wire emit = adv && (state == DVP_ISO || state == DVP_CIP0 || state == DVP_CIP1 || pop_now);
	wire q_last = q_idx == 7'(SRC_QUADS - 1);

	// dif replacement: words 0-1 from registers unless the app supplies them
	wire hdif_pkt = hdif_ins && hdif_cnt == 5'd0;
	wire in_hdif = hdif_pkt && q_idx < 7'(HDIF_QUADS);
	wire use_app = !in_hdif || (hdif_app && q_idx < 7'd2);
	wire [31:0] hdif_word = q_idx == 7'd0 ? hdif0 : q_idx == 7'd1 ? hdif1 : HDIF_FILL;
	wire [31:0] data_word = use_app ? out_s.data : hdif_word;

	// header words: only length, dbc and syt are computed
	wire [15:0] len = is_src ? SRC_LEN : NIL_LEN;
	wire [31:0] iso_word = {len, iso_fields[15:0]};
	wire [31:0] cip0_word = cip_ins ? {cip0[31:8], dbc} : cip0;
	wire ts_use = ts_pending && (!ts_frame || is_src);
	wire [15:0] syt_now = ts_use ? syt : SYT_NONE;
	wire [31:0] cip1_word = cip_ins ? {cip1[31:16], syt_now} : cip1;

	// next state of the builder
	always_comb
	begin
		next_state = state;
		case (state)
			DVP_IDLE: if (start_pkt) next_state = DVP_ISO;
			DVP_ISO: if (adv) next_state = DVP_CIP0;
			DVP_CIP0: if (adv) next_state = DVP_CIP1;
			DVP_CIP1: if (adv) next_state = is_src ? DVP_DATA : DVP_IDLE;
			DVP_DATA: if (pop_now && q_last) next_state = DVP_IDLE;
			default: next_state = DVP_IDLE;
		endcase
	end

	// state, packet kind, word index and dif period counter
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			state <= DVP_IDLE;
			is_src <= 1'b0;
			q_idx <= '0;
			hdif_cnt <= '0;
		end
		else
		begin
			state <= next_state;
			if (start_pkt)
			begin
				is_src <= send_src;
				q_idx <= '0;
			end
			else if (pop_now)
				q_idx <= q_idx + 7'd1;
			if (pop_now && q_last)
				hdif_cnt <= hdif_cnt == 5'(HDIF_PERIOD - 1) ? 5'd0 : hdif_cnt + 5'd1;
		end
	end

	// dbc moves only when a source packet's first cip word leaves
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
			dbc <= '0;
		else if (state == DVP_CIP0 && adv && is_src)
			dbc <= dbc + DBLK_PER_SRC;
	end

	// timestamp armed per cycle or per frame; a new arm beats consumption
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			ts_pending <= 1'b0;
			ts_armed <= 1'b0;
			syt <= SYT_NONE;
		end
		else
		begin
			ts_armed <= ts_en && (ts_frame ? frame_edge : cs_event);
			if (ts_armed)
			begin
				ts_pending <= 1'b1;
				syt <= pace_free;
			end
			else if (state == DVP_CIP1 && adv && ts_use)
				ts_pending <= 1'b0;
		end
	end

	// output stage holds each word until the link takes it
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			tx_valid_out <= 1'b0;
			tx_data_out <= '0;
			tx_last_out <= 1'b0;
		end
		else if (adv)
		begin
			tx_valid_out <= emit;
			tx_last_out <= (state == DVP_CIP1 && !is_src) || (pop_now && q_last);
			case (state)
				DVP_ISO: tx_data_out <= iso_word;
				DVP_CIP0: tx_data_out <= cip0_word;
				DVP_CIP1: tx_data_out <= cip1_word;
				DVP_DATA: tx_data_out <= data_word;
				default: tx_data_out <= tx_data_out;
			endcase
		end
	end

	// ----------------------------------------
	// status and event outputs
	// ----------------------------------------
	assign status = {7'h00, ev_idx, dbc, 4'h0, sigtype_hd, state != DVP_IDLE, !sigtype_ok, started};

	// one-cycle pulses, registered
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			cycle_sync_out <= 1'b0;
			src_event_out <= 1'b0;
		end
		else
		begin
			cycle_sync_out <= cs_event;
			src_event_out <= src_event;
		end
	end
endmodule

// ---- sim/dvp_props.sv ----
// checker for the dv transmit pacer, bound to its top module
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module dvp_props #(
	parameter int CYCLE_CLKS = 200
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic [8:0] cfg_addr_in,
	input wire logic cfg_rd_in,
	input wire logic [dvp_pkg::WORD_W-1:0] cfg_rdata_out,
	input wire logic tx_valid_out,
	input wire logic [dvp_pkg::WORD_W-1:0] tx_data_out,
	input wire logic tx_last_out,
	input wire logic tx_ready_in,
	input wire logic cycle_sync_out,
	input wire logic src_event_out
);
	import dvp_pkg::*;
	localparam int CS_LAST = CYCLE_CLKS - 1;
	logic [15:0] cs_cnt;
	logic [15:0] src_cnt;
	logic [7:0] wcnt;
	logic [15:0] hdr_len;
	logic cs_seen;
	logic src_seen;
	wire logic hs = tx_valid_out && tx_ready_in;
	// -----------------------------
	// helper counters
	// -----------------------------
	// restart at each pulse, so spacing is measured pulse to pulse
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			cs_cnt <= 16'h0000;
			src_cnt <= 16'h0000;
			wcnt <= 8'h00;
			hdr_len <= 16'h0000;
			cs_seen <= 1'b0;
			src_seen <= 1'b0;
		end
		else
		begin
			cs_cnt <= cycle_sync_out ? 16'h0000 : cs_cnt + 16'h0001;
			src_cnt <= src_event_out ? 16'h0000 : src_cnt + 16'h0001;
			cs_seen <= cs_seen || cycle_sync_out;
			src_seen <= src_seen || src_event_out;
			if (hs)
				wcnt <= tx_last_out ? 8'h00 : wcnt + 8'h01;
			if (hs && wcnt == 8'h00)
				hdr_len <= tx_data_out[31:16];
		end
	end
	// -----------------------------
	// properties
	// -----------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	sequence s_first;
		hs && wcnt == 8'h00;
	endsequence
	sequence s_start;
		$rose(tx_valid_out) && wcnt == 8'h00;
	endsequence
	property p_cs_period;
		cycle_sync_out && cs_seen |-> cs_cnt == 16'(CS_LAST);
	endproperty
	a_cs_period: assert property (p_cs_period) else $error("cycle sync spacing wrong");
	property p_cs_pulse;
		$rose(cycle_sync_out) |=> !cycle_sync_out [*8];
	endproperty
	a_cs_pulse: assert property (p_cs_pulse) else $error("cycle sync pulse too long");
	property p_start;
		s_start |-> $past(cycle_sync_out) || $past(cycle_sync_out, 2) || $past(cycle_sync_out, 3);
	endproperty
	a_start: assert property (p_start) else $error("packet start not after cycle sync");
	property p_hold;
		tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out) && $stable(tx_last_out);
	endproperty
	a_hold: assert property (p_hold) else $error("stalled word changed");
	property p_len;
		s_first |-> tx_data_out[31:16] == SRC_LEN || tx_data_out[31:16] == NIL_LEN;
	endproperty
	a_len: assert property (p_len) else $error("bad length field");
	property p_last;
		tx_valid_out && tx_last_out |-> (hdr_len == NIL_LEN && wcnt == 8'h02) || (hdr_len == SRC_LEN && wcnt == 8'h7a);
	endproperty
	a_last: assert property (p_last) else $error("packet size disagrees with length");
	property p_src_gap;
		src_event_out && src_seen |-> src_cnt inside {16'h199f, 16'h19c7, 16'h1999, 16'h1921};
	endproperty
	a_src_gap: assert property (p_src_gap) else $error("source event spacing wrong");
	property p_bulk;
		cfg_rd_in && cfg_addr_in == OFF_BULK_PART |=> cfg_rdata_out[1:0] == 2'h0;
	endproperty
	a_bulk: assert property (p_bulk) else $error("bulky partition not hexlet sized");
	property p_ctrl;
		cfg_rd_in && cfg_addr_in == OFF_CTRL_PART |=> cfg_rdata_out[31:24] == 8'h00;
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control partition too wide");
endmodule
bind dvp_pacer dvp_props #(.CYCLE_CLKS(CYCLE_CLKS)) dvp_props_inst (
	.ref_clk_in(ref_clk_in),
	.reset_in(reset_in),
	.cfg_addr_in(cfg_addr_in),
	.cfg_rd_in(cfg_rd_in),
	.cfg_rdata_out(cfg_rdata_out),
	.tx_valid_out(tx_valid_out),
	.tx_data_out(tx_data_out),
	.tx_last_out(tx_last_out),
	.tx_ready_in(tx_ready_in),
	.cycle_sync_out(cycle_sync_out),
	.src_event_out(src_event_out)
);

// ---- sim/dvp_app_model.sv ----
// application model: feeds 120-word packets into the bulky data port
// assumes the pacer samples on rising edges of the shared clock
`timescale 1ns/1ps
module dvp_app_model (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic load_in,
	input wire logic slow_in,
	input wire logic frame_req_in,
	input wire logic bdp_ready_in,
	output logic bdp_valid_out,
	output logic [dvp_pkg::WORD_W-1:0] bdp_data_out,
	output logic src_ready_out,
	output logic frame_pulse_out
);
	import dvp_pkg::*;
	logic [7:0] pkt;
	logic [7:0] idx;
	logic [1:0] pace;
	// word 119 closes a packet; slow mode offers one word in four
	wire logic taken = bdp_valid_out && bdp_ready_in;
	wire logic wrap = taken && idx == 8'h77;
	wire logic [7:0] next_idx = wrap ? 8'h00 : idx + 8'(taken);
	wire logic [7:0] next_pkt = pkt + 8'(wrap);
	wire logic offer = load_in && (!slow_in || pace == 2'h0);
	// whole packet held while loaded, header dif bytes included
	assign src_ready_out = load_in;
	// idle port shows inverted data so stale words never look valid
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			pkt <= 8'h00;
			idx <= 8'h00;
			pace <= 2'h0;
			bdp_valid_out <= 1'b0;
			bdp_data_out <= 32'h00000000;
			frame_pulse_out <= 1'b0;
		end
		else
		begin
			frame_pulse_out <= frame_req_in;
			pace <= pace + 2'h1;
			pkt <= next_pkt;
			idx <= next_idx;
			if (!bdp_valid_out || taken)
			begin
				bdp_valid_out <= offer;
				bdp_data_out <= offer ? {8'ha5, next_pkt, 8'h00, next_idx} : ~bdp_data_out;
			end
		end
	end
endmodule

// ---- sim/dv_transmit_pacer_bench.sv ----
// self-checking bench for the dv transmit pacer
// assumes a 50 MHz clock and an iso cycle shortened to 200 clocks
`timescale 1ns/1ps
module dv_transmit_pacer_bench;
	import dvp_pkg::*;
	logic ref_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [8:0] cfg_addr_in = 9'h000;
	logic cfg_wr_in = 1'b0;
	logic cfg_rd_in = 1'b0;
	logic [31:0] cfg_wdata_in = 32'h00000000;
	logic frame_req = 1'b0;
	logic load = 1'b0;
	logic slow = 1'b0;
	logic stall = 1'b0;
	logic tx_ready_in = 1'b1;
	logic frame_sync_pulse_in, src_packet_ready_in, bdp_valid_in, bdp_ready_out;
	logic tx_valid_out, tx_last_out, cycle_sync_out, src_event_out;
	logic [31:0] cfg_rdata_out, bdp_data_in, tx_data_out;
	logic [31:0] cur[$];
	logic [31:0] pk[$];
	int npk = 0;
	int fail_count = 0;
	int tests_run = 0;
	always #10 ref_clk_in = ~ref_clk_in;
	// toggling ready stalls the link on every other cycle
	always @(negedge ref_clk_in)
		tx_ready_in <= stall ? ~tx_ready_in : 1'b1;
	// gather accepted words into whole packets
	always @(posedge ref_clk_in)
		if (tx_valid_out === 1'b1 && tx_ready_in)
		begin
			cur.push_back(tx_data_out);
			if (tx_last_out === 1'b1)
			begin
				pk = cur;
				cur = {};
				npk++;
			end
		end
	dvp_pacer #(.CYCLE_CLKS(200)) dvp_pacer_inst (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.cfg_addr_in(cfg_addr_in),
		.cfg_wr_in(cfg_wr_in),
		.cfg_rd_in(cfg_rd_in),
		.cfg_wdata_in(cfg_wdata_in),
		.cfg_rdata_out(cfg_rdata_out),
		.frame_sync_pulse_in(frame_sync_pulse_in),
		.src_packet_ready_in(src_packet_ready_in),
		.bdp_valid_in(bdp_valid_in),
		.bdp_data_in(bdp_data_in),
		.bdp_ready_out(bdp_ready_out),
		.tx_valid_out(tx_valid_out),
		.tx_data_out(tx_data_out),
		.tx_last_out(tx_last_out),
		.tx_ready_in(tx_ready_in),
		.cycle_sync_out(cycle_sync_out),
		.src_event_out(src_event_out)
	);
	dvp_app_model dvp_app_model_inst (
		.clk_in(ref_clk_in),
		.reset_in(reset_in),
		.load_in(load),
		.slow_in(slow),
		.frame_req_in(frame_req),
		.bdp_ready_in(bdp_ready_out),
		.bdp_valid_out(bdp_valid_in),
		.bdp_data_out(bdp_data_in),
		.src_ready_out(src_packet_ready_in),
		.frame_pulse_out(frame_sync_pulse_in)
	);
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(negedge ref_clk_in);
		cfg_addr_in = a;
		cfg_wdata_in = d;
		cfg_wr_in = 1'b1;
		@(negedge ref_clk_in);
		cfg_wr_in = 1'b0;
	endtask
	task automatic rd(input logic [8:0] a, output logic [31:0] d);
		@(negedge ref_clk_in);
		cfg_addr_in = a;
		cfg_rd_in = 1'b1;
		@(negedge ref_clk_in);
		cfg_rd_in = 1'b0;
		d = cfg_rdata_out;
	endtask
	task automatic wait_pkt;
		int n0;
		n0 = npk;
		repeat (3000)
			if (npk == n0)
				@(negedge ref_clk_in);
		chk("packet arrival", 32'h1, 32'(npk != n0));
	endtask
	task automatic next_ev(output int n);
		n = 0;
		do
		begin
			@(negedge ref_clk_in);
			n++;
		end
		while (src_event_out !== 1'b1 && n < 20000);
	endtask
	// expected packet word i of the j-th source packet
	function automatic logic [31:0] ex(input int j, input int i, input logic app8);
		if (i == 0)
			return {SRC_LEN, 16'h0a60};
		if (i == 1)
			return {24'h017800, 8'(j)};
		if (i == 2)
			return {16'h8080, SYT_NONE};
		if (j % 25 == 0 && i < 23 && !(app8 && i < 5))
			return i == 3 ? 32'h12345678 : i == 4 ? 32'h9abcdef0 : HDIF_FILL;
		return {8'ha5, 8'(j), 8'h00, 8'(i - 3)};
	endfunction
	task automatic t_regs;
		logic [8:0] offs[8] = '{OFF_TS_CTRL, OFF_HDIF0, OFF_HDIF1, OFF_CIP0, OFF_CIP1, OFF_ISOHDR,
			OFF_BULK_PART, OFF_CTRL_PART};
		logic [31:0] vals[8] = '{32'h00000800, 32'h12345678, 32'h9abcdef0, 32'h01780000, 32'h80000000,
			32'h00000a60, 32'hffffffff, 32'hffffffff};
		logic [31:0] d;
		rd(OFF_MODE, d);
		chk("mode reset", MODE_RESET, d);
		foreach (offs[k])
		begin
			rd(offs[k], d);
			chk("reg reset", ZERO_RESET, d);
			wr(offs[k], vals[k]);
			rd(offs[k], d);
			chk("reg readback", k == 6 ? 32'hfffffffc : k == 7 ? 32'h00ffffff : vals[k], d);
		end
		wr(9'h100, 32'hffffffff);
		rd(9'h100, d);
		chk("unmapped read", ZERO_RESET, d);
		for (int c = 0; c < 3; c++)
		begin
			wr(OFF_CIP1, 32'h80000000 | (32'(2 - c) << SIGTYPE_LSB));
			rd(OFF_STATUS, d);
			chk("signal type flags", 32'(2 - c), {30'h0, d[3], d[1]});
		end
	endtask
	task automatic t_empty;
		wr(OFF_TS_CTRL, 32'h00000001);
		wr(OFF_MODE, 32'h00000013);
		load = 1'b1;
		repeat (2)
		begin
			wait_pkt;
			chk("empty size", 32'h3, 32'(pk.size()));
			chk("empty iso", {NIL_LEN, 16'h0a60}, pk[0]);
			chk("empty cip0", 32'h01780000, pk[1]);
			chk("empty cip1", 32'h00008000, 32'(pk[2][31:16]));
			chk("empty syt", 32'h1, 32'(pk[2][15:0] != SYT_NONE));
		end
		wr(OFF_TS_CTRL, ZERO_RESET);
		chk("fifo full ready", 32'h0, {31'h0, bdp_ready_out});
	endtask
	task automatic t_pace;
		int n;
		load = 1'b0;
		frame_req = 1'b1;
		@(negedge ref_clk_in);
		frame_req = 1'b0;
		next_ev(n);
		next_ev(n);
		chk("ntsc gap", 32'h000019a0, 32'(n));
		wr(OFF_CIP1, 32'h80800000);
		next_ev(n);
		next_ev(n);
		chk("pal gap", 32'h0000199a, 32'(n));
		wait_pkt;
		chk("no data empty", 32'h3, 32'(pk.size()));
	endtask
	task automatic t_source;
		int j;
		j = 0;
		wr(OFF_MODE, 32'h00000016);
		load = 1'b1;
		slow = 1'b1;
		stall = 1'b1;
		repeat (80)
			if (j < 26)
			begin
				wait_pkt;
				if (pk.size() != 3)
				begin
					chk("source size", 32'h7b, 32'(pk.size()));
					for (int i = 0; i < 123; i++)
						chk("source word", ex(j, i, j > 0), pk[i]);
					j++;
				end
				if (j == 2)
				begin
					stall = 1'b0;
					slow = 1'b0;
					wr(OFF_MODE, 32'h0000001e);
				end
			end
		chk("source count", 32'h1a, 32'(j));
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(negedge ref_clk_in);
		reset_in = 1'b0;
		t_regs;
		$display("register test done");
		t_empty;
		$display("empty packet test done");
		t_pace;
		$display("pacing test done");
		t_source;
		$display("source packet test done");
		tally_and_finish;
	end
	// about 35k cycles expected; cut off at 100k
	initial
	begin
		#2000000;
		fail_count++;
		$display("ERROR watchdog expected finish seen timeout");
		tally_and_finish;
	end
endmodule
